// ### mps_map.svh
// Purpose: Timing and pattern constants for the power-on sequencer
// Assumes: 50 MHz system clock, millisecond timebase
// Notes:   Definitions only
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH
`define MPS_CLK_HZ          50000000
`define MPS_MS_PER_S        1000
`define MPS_TICK_CYC        (`MPS_CLK_HZ / `MPS_MS_PER_S)
`define MPS_RESET_END_MS    100
`define MPS_HWINIT_END_MS   5000
`define MPS_FWINIT_END_MS   36000
`define MPS_CARD_ON_MS      50
`define MPS_CARD_OFF_MS     950
`define MPS_CARD_PWR_DLY_MS 3000
`define MPS_ALIVE_HALF_MS   5000
`define MPS_BURST1_MS       11000
`define MPS_BURST2_MS       13000
`define MPS_BURST_LEN_MS    50
`define MPS_IGN_FILT_CYC    8
`define MPS_HOST_IGN_MS     100
`endif

// ### mps_pkg.sv
// Purpose: Shared types of the power-on sequencer
// Assumes: nothing
// Notes:   Phases follow the start-up order
package mps_pkg;
   typedef enum logic [2:0] {
      MPS_POWER_DOWN,
      MPS_RESET_PHASE,
      MPS_HW_INIT,
      MPS_FW_INIT,
      MPS_ACTIVE
   } mps_phase_t;
   typedef enum logic [1:0] {
      MPS_MODE_OFF,
      MPS_MODE_IDLE,
      MPS_MODE_SLEEP
   } mps_mode_t;
endpackage : mps_pkg

// ### mps_link_if.sv
// Purpose: Link between the host controller and the module sequencer
// Assumes: one clock shared by both ends
// Notes:   Ignition line is open drain, resolved here
`timescale 1ns/1ns
interface mps_link_if;
   logic ignition_line_oe;
   logic ignition_line;
   logic ready_notification;
   logic airplane_mode;
   logic power_indicator;
   logic host_char;
   logic device_answer;
   // ------------------------------
   // Open drain: low while driven
   // ------------------------------
   assign ignition_line = ~ignition_line_oe;
   modport device (
      input  ignition_line,
      input  host_char,
      output ready_notification,
      output airplane_mode,
      output power_indicator,
      output device_answer
   );
   modport host (
      output ignition_line_oe,
      input  ignition_line,
      output host_char,
      input  ready_notification,
      input  airplane_mode,
      input  power_indicator,
      input  device_answer
   );
endinterface : mps_link_if

// ### mps_device.sv
// Purpose: Module power-on sequencer, device end
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   Phase timing counted in milliseconds from ignition
`timescale 1ns/1ns
`include "mps_map.svh"
// What this block does
// (R1) Power-down: low ignition starts power-on
// (R2) Host drives ignition open-drain only
// (R3) Host holds ignition low 100ms
// (R4) Host releases ignition after turn-on
// (R5) Ready notification after start, mode flagged
// (R6) Host waits ready or polls characters
// (R7) Supply or temperature fault: switch off; ignored during the reset phase
// (R8) Phases: reset, hw init, fw init, active
// (R9) Defined output states after firmware init
// (R10) Card data/cmd: 50ms up, 950ms down
// (R11) Card clock toggles 50ms, 950ms low
// (R12) Card supply pulses from 3s into fw init
// (R13) Alive pulse 0.1Hz after hw init low
// (R14) Host-link bursts at 11s and 13s
// (R15) Sleep only when all activity is absent
// (R16) Idle while saving off or USB idle
// (R17) Power down: only clock regulator on
// (R18) Power indicator high when off
// (R19) Millisecond tick counts all phase and pattern timing
// (R20) Ignition synchronised and filtered
module mps_device #(
   parameter int TICK_CYC = `MPS_TICK_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Link
   mps_link_if.device link,
   // Status inputs
   input  wire logic supply_fault,
   input  wire logic temp_fault,
   input  wire logic airplane_req,
   input  wire logic call_active,
   input  wire logic usb_attached,
   input  wire logic usb_transfer,
   input  wire logic serial_active,
   input  wire logic antenna_auto_or_off,
   input  wire logic power_saving_en,
   // Pattern, power, phase and mode outputs
   output logic [3:0] card_data_pu,
   output logic       card_cmd_pu,
   output logic       card_clk,
   output logic       card_supply_enable,
   output logic       alive_pulse_out,
   output logic       host_link_reset_n,
   output logic       host_link_lanes,
   output logic       rtc_regulator_on,
   output logic       core_enable,
   output mps_pkg::mps_phase_t phase,
   output mps_pkg::mps_mode_t  mode
);
   logic [1:0]  ign_sync_q;
   logic [3:0]  ign_cnt_q;
   logic        ign_low_q;
   logic [15:0] tick_cnt_q;
   logic        tick_q;
   logic [15:0] ms_q;
   logic [9:0]  card_ms_q;
   logic [12:0] alive_ms_q;
   logic        fault_on;
   logic        card_on;
   logic        burst;

   // ------------------------------
   // Ignition input
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ign_sync_q <= 2'h3;
         ign_cnt_q  <= 4'h0;
         ign_low_q  <= 1'b0;
      end
      else
      begin
         ign_sync_q <= {ign_sync_q[0], link.ignition_line}; // (R20)
         if (ign_sync_q[1])
         begin
            ign_cnt_q <= 4'h0;
            ign_low_q <= 1'b0;
         end
         else if (ign_cnt_q == 4'(`MPS_IGN_FILT_CYC))
            ign_low_q <= 1'b1; // (R20)
         else
            ign_cnt_q <= ign_cnt_q + 4'h1;
      end
   end

   // ------------------------------
   // Millisecond tick
   // ------------------------------
   // Restarted at ignition so phase boundaries align to it
   always_ff @(posedge clock)
   begin
      if (reset || phase == mps_pkg::MPS_POWER_DOWN)
      begin
         tick_cnt_q <= 16'h0;
         tick_q     <= 1'b0;
      end
      else if (tick_cnt_q == 16'(TICK_CYC - 1))
      begin
         tick_cnt_q <= 16'h0;
         tick_q     <= 1'b1; // (R19)
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 16'h1;
         tick_q     <= 1'b0;
      end
   end

   // ------------------------------
   // Phase sequencer
   // ------------------------------
   assign fault_on = supply_fault | temp_fault;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         phase <= mps_pkg::MPS_POWER_DOWN;
         ms_q  <= 16'h0;
      end
      else
      begin
         unique case (phase)
            mps_pkg::MPS_POWER_DOWN:
            begin
               ms_q <= 16'h0;
               if (ign_low_q)
                  phase <= mps_pkg::MPS_RESET_PHASE; // (R1)
            end
            mps_pkg::MPS_RESET_PHASE, mps_pkg::MPS_HW_INIT, mps_pkg::MPS_FW_INIT, mps_pkg::MPS_ACTIVE:
            begin
               if (fault_on && phase != mps_pkg::MPS_RESET_PHASE)
                  phase <= mps_pkg::MPS_POWER_DOWN; // (R7)
               else if (tick_q)
               begin
                  if (phase != mps_pkg::MPS_ACTIVE)
                     ms_q <= ms_q + 16'h1;
                  if (ms_q == 16'(`MPS_RESET_END_MS - 1))
                     phase <= mps_pkg::MPS_HW_INIT; // (R8)
                  else if (ms_q == 16'(`MPS_HWINIT_END_MS - 1))
                     phase <= mps_pkg::MPS_FW_INIT; // (R8)
                  else if (ms_q == 16'(`MPS_FWINIT_END_MS - 1))
                     phase <= mps_pkg::MPS_ACTIVE; // (R8)
               end
            end
         endcase
      end
   end

   // ------------------------------
   // Periodic patterns
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset || phase == mps_pkg::MPS_POWER_DOWN || phase == mps_pkg::MPS_RESET_PHASE
          || phase == mps_pkg::MPS_HW_INIT)
      begin
         card_ms_q  <= 10'h0;
         alive_ms_q <= 13'h0;
      end
      else if (tick_q)
      begin
         card_ms_q  <= (card_ms_q == 10'(`MPS_CARD_ON_MS + `MPS_CARD_OFF_MS - 1)) ? 10'h0
                       : card_ms_q + 10'h1; // (R10)
         alive_ms_q <= (alive_ms_q == 13'(`MPS_ALIVE_HALF_MS - 1)) ? 13'h0 : alive_ms_q + 13'h1;
      end
   end

   assign card_on = card_ms_q < 10'(`MPS_CARD_ON_MS);
   // Bursts only fall inside firmware init, ms counter is frozen after it
   assign burst = phase == mps_pkg::MPS_FW_INIT
                  && ((ms_q >= 16'(`MPS_BURST1_MS) && ms_q < 16'(`MPS_BURST1_MS + `MPS_BURST_LEN_MS))
                  || (ms_q >= 16'(`MPS_BURST2_MS) && ms_q < 16'(`MPS_BURST2_MS + `MPS_BURST_LEN_MS)));

   // ------------------------------
   // Output states
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         card_data_pu       <= 4'h0;
         card_cmd_pu        <= 1'b0;
         card_clk           <= 1'b0;
         card_supply_enable <= 1'b0;
         alive_pulse_out    <= 1'b0;
         host_link_reset_n  <= 1'b0;
         host_link_lanes    <= 1'b0;
      end
      else if (phase == mps_pkg::MPS_FW_INIT || phase == mps_pkg::MPS_ACTIVE)
      begin
         card_data_pu       <= {4{card_on}}; // (R10)
         card_cmd_pu        <= card_on; // (R10)
         card_clk           <= card_on & ~card_clk; // (R11)
         card_supply_enable <= card_on && (phase == mps_pkg::MPS_ACTIVE
                               || ms_q >= 16'(`MPS_HWINIT_END_MS + `MPS_CARD_PWR_DLY_MS)); // (R12)
         if (tick_q && alive_ms_q == 13'(`MPS_ALIVE_HALF_MS - 1))
            alive_pulse_out <= ~alive_pulse_out; // (R13)
         else if (phase == mps_pkg::MPS_FW_INIT && ms_q == 16'(`MPS_HWINIT_END_MS))
            alive_pulse_out <= 1'b1; // (R13)
         host_link_reset_n  <= burst; // (R14)
         host_link_lanes    <= burst & ~host_link_lanes; // (R14)
      end
      else
      begin
         // Defined low states outside the running phases
         card_data_pu       <= 4'h0; // (R9)
         card_cmd_pu        <= 1'b0;
         card_clk           <= 1'b0;
         card_supply_enable <= 1'b0;
         alive_pulse_out    <= 1'b0; // (R13)
         host_link_reset_n  <= 1'b0;
         host_link_lanes    <= 1'b0;
      end
   end

   // ------------------------------
   // Power modes and host status
   // ------------------------------
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         mode                    <= mps_pkg::MPS_MODE_OFF;
         link.ready_notification <= 1'b0;
         link.airplane_mode      <= 1'b0;
         link.power_indicator    <= 1'b1;
         link.device_answer      <= 1'b0;
         rtc_regulator_on        <= 1'b1;
         core_enable             <= 1'b0;
      end
      else
      begin
         rtc_regulator_on     <= 1'b1; // (R17)
         core_enable          <= phase != mps_pkg::MPS_POWER_DOWN; // (R17)
         link.power_indicator <= phase == mps_pkg::MPS_POWER_DOWN; // (R18)
         link.ready_notification <= phase == mps_pkg::MPS_ACTIVE; // (R5)
         link.airplane_mode   <= phase == mps_pkg::MPS_ACTIVE && airplane_req; // (R5)
         link.device_answer   <= phase == mps_pkg::MPS_ACTIVE && link.host_char; // (R6)
         if (phase != mps_pkg::MPS_ACTIVE)
            mode <= mps_pkg::MPS_MODE_OFF;
         else if (!power_saving_en || (usb_attached && !usb_transfer))
            mode <= mps_pkg::MPS_MODE_IDLE; // (R16)
         else if (!call_active && !usb_attached && !serial_active && antenna_auto_or_off)
            mode <= mps_pkg::MPS_MODE_SLEEP; // (R15)
         else
            mode <= mps_pkg::MPS_MODE_IDLE;
      end
   end
endmodule : mps_device

// ### mps_host.sv
// Purpose: Host controller end of the power-on link
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   Ignition held low 100ms, then released
`timescale 1ns/1ns
`include "mps_map.svh"
module mps_host #(
   parameter int IGN_CYC = `MPS_HOST_IGN_MS * `MPS_TICK_CYC
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic reset,
   // Link
   mps_link_if.host link,
   // User side
   input  wire logic power_on_req,
   input  wire logic poll_en,
   output logic      busy,
   output logic      ready,
   output logic      module_off
);
   typedef enum logic [1:0] {HST_IDLE, HST_IGNITE, HST_WAIT} mps_hst_state_t;
   mps_hst_state_t state_q;
   logic [22:0] cnt_q;
   logic [1:0]  rdy_sync_q;
   logic [1:0]  ans_sync_q;
   logic [1:0]  pwr_sync_q;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         rdy_sync_q <= 2'h0;
         ans_sync_q <= 2'h0;
         pwr_sync_q <= 2'h3;
      end
      else
      begin
         rdy_sync_q <= {rdy_sync_q[0], link.ready_notification};
         ans_sync_q <= {ans_sync_q[0], link.device_answer};
         pwr_sync_q <= {pwr_sync_q[0], link.power_indicator};
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_q               <= HST_IDLE;
         cnt_q                 <= 23'h0;
         link.ignition_line_oe <= 1'b0;
         link.host_char        <= 1'b0;
         busy                  <= 1'b0;
         ready                 <= 1'b0;
         module_off            <= 1'b1;
      end
      else
      begin
         module_off <= pwr_sync_q[1];
         unique case (state_q)
            HST_IDLE:
            begin
               link.host_char <= 1'b0;
               if (power_on_req && pwr_sync_q[1])
               begin
                  state_q               <= HST_IGNITE;
                  cnt_q                 <= 23'h0;
                  link.ignition_line_oe <= 1'b1; // (R2)
                  busy                  <= 1'b1;
                  ready                 <= 1'b0;
               end
            end
            HST_IGNITE:
            begin
               cnt_q <= cnt_q + 23'h1;
               if (cnt_q == 23'(IGN_CYC - 1))
               begin
                  link.ignition_line_oe <= 1'b0; // (R3) (R4)
                  state_q               <= HST_WAIT;
               end
            end
            HST_WAIT:
            begin
               link.host_char <= poll_en & ~link.host_char; // (R6)
               if (rdy_sync_q[1] || (poll_en && ans_sync_q[1]))
               begin
                  ready   <= 1'b1; // (R6)
                  busy    <= 1'b0;
                  state_q <= HST_IDLE;
               end
            end
         endcase
      end
   end
endmodule : mps_host

// ### mps_link_props.sv
// Purpose: Link checks for the power-on sequencer
// Assumes: one clock, sync active-high reset
// Notes:   Sees only the link signals
`timescale 1ns/1ns
`include "mps_map.svh"
module mps_link_props #(
   parameter int TICK_CYC = 50000,
   parameter int IGN_CYC  = 5000000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Link
   input wire logic ignition_line_oe,
   input wire logic ignition_line,
   input wire logic ready_notification,
   input wire logic airplane_mode,
   input wire logic power_indicator,
   input wire logic host_char,
   input wire logic device_answer
);
   // ----------------
   // Helper counters
   // ----------------
   logic [31:0] oe_cnt_q;
   logic [31:0] ign_cnt_q;
   always_ff @(posedge clock)
   begin
      oe_cnt_q <= (reset || !ignition_line_oe) ? 32'h0 : oe_cnt_q + 32'h1;
   end
   // Counts from the first cycle of ignition
   always_ff @(posedge clock)
   begin
      ign_cnt_q <= (reset || (ignition_line_oe && oe_cnt_q == 32'h0)) ? 32'h0 : ign_cnt_q + 32'h1;
   end
   // ----------------
   // Properties
   // ----------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_ignite;
      $rose(ignition_line_oe) ##1 ignition_line_oe;
   endsequence
   chk_open_drain: assert property (ignition_line == !ignition_line_oe)
      else $error("ignition line level wrong");
   chk_ign_order: assert property (s_ignite |-> $past(power_indicator, 2))
      else $error("ignition while module running");
   chk_ign_hold: assert property ($fell(ignition_line_oe) |-> oe_cnt_q >= IGN_CYC)
      else $error("ignition pulse too short");
   chk_ign_release: assert property (ignition_line_oe |-> oe_cnt_q <= IGN_CYC + 2)
      else $error("ignition not released");
   chk_ready_time: assert property ($rose(ready_notification) |->
      ign_cnt_q >= `MPS_FWINIT_END_MS * TICK_CYC && ign_cnt_q <= `MPS_FWINIT_END_MS * TICK_CYC + 40)
      else $error("ready at wrong time");
   chk_ready_led: assert property (ready_notification |-> !power_indicator)
      else $error("indicator high while ready");
   chk_ready_drop: assert property ($fell(ready_notification) |-> ##[0:3] power_indicator)
      else $error("ready lost without power down");
   chk_answer_echo: assert property (ready_notification [*2] |-> device_answer == $past(host_char))
      else $error("answer does not follow poll");
   chk_ind_reset: assert property ($fell(reset) |-> power_indicator && !ready_notification)
      else $error("indicator low after reset");
   cov_ignite: cover property (s_ignite);
endmodule : mps_link_props

// ### tb_top.sv
// Purpose: Bench for host and device ends
// Assumes: tick shortened to 2 cycles
// Notes:   Phase notes checked by a watcher
`timescale 1ns/1ns
module tb_top;
   localparam int T   = 2;
   localparam int IGN = 200;
   typedef struct {mps_pkg::mps_phase_t ph; int ms;} mps_note_t;
   logic clock, reset, supply_fault, temp_fault, airplane_req, call_active, usb_attached;
   logic usb_transfer, serial_active, antenna_auto_or_off, power_saving_en, power_on_req, poll_en;
   logic [3:0] card_data_pu;
   logic card_cmd_pu, card_clk, card_supply_enable, alive_pulse_out, host_link_reset_n;
   logic host_link_lanes, rtc_regulator_on, core_enable, busy, ready, module_off, c, idl, slp;
   mps_pkg::mps_phase_t phase;
   mps_pkg::mps_mode_t  mode;
   mps_note_t notes[$];
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0 = 0;
   int pms[9] = '{3000, 5025, 5500, 8025, 10025, 11025, 11500, 13025, 15025};
   logic [7:0] pexp[9] = '{8'h00, 8'hFA, 8'h02, 8'hFE, 8'hFC, 8'hFD, 8'h00, 8'hFD, 8'hFE};
   mps_link_if u_mps_link_if ();
   mps_device #(.TICK_CYC(T)) u_mps_device (.clock(clock), .reset(reset), .link(u_mps_link_if),
      .supply_fault(supply_fault), .temp_fault(temp_fault), .airplane_req(airplane_req),
      .call_active(call_active), .usb_attached(usb_attached), .usb_transfer(usb_transfer),
      .serial_active(serial_active), .antenna_auto_or_off(antenna_auto_or_off),
      .power_saving_en(power_saving_en), .card_data_pu(card_data_pu), .card_cmd_pu(card_cmd_pu),
      .card_clk(card_clk), .card_supply_enable(card_supply_enable), .alive_pulse_out(alive_pulse_out),
      .host_link_reset_n(host_link_reset_n), .host_link_lanes(host_link_lanes),
      .rtc_regulator_on(rtc_regulator_on), .core_enable(core_enable), .phase(phase), .mode(mode));
   mps_host #(.IGN_CYC(IGN)) u_mps_host (.clock(clock), .reset(reset), .link(u_mps_link_if),
      .power_on_req(power_on_req), .poll_en(poll_en), .busy(busy), .ready(ready), .module_off(module_off));
   mps_link_props #(.TICK_CYC(T), .IGN_CYC(IGN)) u_mps_link_props (.clock(clock), .reset(reset),
      .ignition_line_oe(u_mps_link_if.ignition_line_oe), .ignition_line(u_mps_link_if.ignition_line),
      .ready_notification(u_mps_link_if.ready_notification), .airplane_mode(u_mps_link_if.airplane_mode),
      .power_indicator(u_mps_link_if.power_indicator), .host_char(u_mps_link_if.host_char),
      .device_answer(u_mps_link_if.device_answer));
   // ----------------
   // Clock and timeout
   // ----------------
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------
   // Shared tasks
   // ----------------
   task automatic cmp_v(input string what, input logic [7:0] exp, input logic [7:0] seen);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : cmp_v
   task automatic cmp_t(input string what, input int exp, input int seen);
      n_compared++;
      if (seen < exp - 16 || seen > exp + 16)
      begin
         n_mismatch++;
         $display("mismatch %s expected %0d seen %0d", what, exp, seen);
      end
   endtask : cmp_t
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask : step
   task automatic wait_phase(input mps_pkg::mps_phase_t ph, input int lim);
      while (phase !== ph && lim > 0)
      begin
         step(1);
         lim--;
      end
      cmp_v("phase_reached", 8'(ph), 8'(phase));
   endtask : wait_phase
   task automatic ignite(input int hw_ms);
      notes.push_back('{mps_pkg::MPS_RESET_PHASE, -1});
      notes.push_back('{mps_pkg::MPS_HW_INIT, hw_ms});
      power_on_req = 1'b1;
      step(3);
      power_on_req = 1'b0;
      wait_phase(mps_pkg::MPS_RESET_PHASE, 40);
      t0 = cyc;
   endtask : ignite
   task automatic close_out;
      if (n_mismatch == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out
   // ----------------
   // Phase watcher
   // ----------------
   initial
   begin : watch
      mps_pkg::mps_phase_t last;
      mps_note_t note;
      @(negedge reset);
      last = mps_pkg::MPS_POWER_DOWN;
      forever
      begin
         @(posedge clock);
         #1;
         if (phase !== last)
         begin
            last = phase;
            if (notes.size() > 0)
               note = notes.pop_front();
            else
            begin
               note.ph = mps_pkg::MPS_ACTIVE;
               note.ms = -1;
            end
            cmp_v("phase", 8'(note.ph), 8'(phase));
            if (note.ms >= 0)
               cmp_t("phase_time", t0 + note.ms * T, cyc);
         end
      end
   end
   // ----------------
   // Main sequence
   // ----------------
   initial
   begin
      {reset, supply_fault, temp_fault, call_active, usb_attached, usb_transfer} = 6'h20;
      {serial_active, antenna_auto_or_off, power_saving_en, power_on_req, poll_en} = 5'h01;
      void'($urandom(32'h572598df));
      airplane_req = 1'($urandom);
      step(5);
      reset = 1'b0;
      step(1);
      cmp_v("off_state", 8'h2D, {rtc_regulator_on, core_enable, u_mps_link_if.power_indicator, module_off, u_mps_link_if.ready_notification, 1'b1});
      ignite(100);
      // Queued behind the reset and hardware init notes
      notes.push_back('{mps_pkg::MPS_FW_INIT, 5000});
      notes.push_back('{mps_pkg::MPS_ACTIVE, 36000});
      for (int i = 0; i < 9; i++)
      begin
         step(t0 + pms[i] * T - cyc);
         cmp_v("card_pattern", pexp[i], {card_data_pu, card_cmd_pu, card_supply_enable, alive_pulse_out, host_link_reset_n});
         c = card_clk;
         step(1);
         cmp_v("card_clk", 8'(pexp[i][7] & !c), 8'(card_clk));
      end
      wait_phase(mps_pkg::MPS_ACTIVE, 25000 * T);
      step(6);
      cmp_v("ready", {6'h0, airplane_req, 1'b1}, {u_mps_link_if.airplane_mode, u_mps_link_if.ready_notification});
      cmp_v("host_state", 8'h08, {ready, busy, module_off, u_mps_link_if.power_indicator});
      for (int i = 0; i < 16; i++)
      begin
         {call_active, usb_attached, usb_transfer, serial_active, antenna_auto_or_off, power_saving_en, poll_en} = 7'($urandom);
         step(4);
         idl = !power_saving_en || (usb_attached && !usb_transfer);
         slp = !call_active && !usb_attached && !serial_active && antenna_auto_or_off;
         cmp_v("mode", (!idl && slp) ? 8'(mps_pkg::MPS_MODE_SLEEP) : 8'(mps_pkg::MPS_MODE_IDLE), 8'(mode));
      end
      notes.push_back('{mps_pkg::MPS_POWER_DOWN, -1});
      supply_fault = 1'b1;
      wait_phase(mps_pkg::MPS_POWER_DOWN, 20);
      step(3);
      cmp_v("fault_off", 8'h03, {core_enable, rtc_regulator_on, u_mps_link_if.power_indicator});
      supply_fault = 1'b0;
      // Fault raised in reset phase only acts from hardware init
      ignite(100);
      notes.push_back('{mps_pkg::MPS_POWER_DOWN, -1});
      temp_fault = 1'b1;
      wait_phase(mps_pkg::MPS_HW_INIT, 120 * T);
      wait_phase(mps_pkg::MPS_POWER_DOWN, 20);
      step(4);
      close_out();
   end
endmodule : tb_top
